// ### core/term_ctrl.sv
// Transfer termination controller: setting registers, byte paths, END marking, DMA select.
// Assumes AHB-Lite single word transfers; byte streams handshaked by valid and accept.
//
// Our own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ns
module term_ctrl
  import term_pkg::*;
#(
  parameter int UNITS = 4,
  parameter logic DMA_CAPABLE = 1'b1,
  parameter logic [1:0] DMA_CHANNEL = DMA_CHANNEL_RESET
)
(
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic xfer_start_in,
  input wire logic xfer_write_in,
  input wire logic xfer_unit_en_in,
  input wire logic [1:0] xfer_unit_in,
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_byte_in,
  input wire logic tx_last_in,
  output logic tx_accept_out,
  output logic [7:0] bus_data_out,
  output logic bus_data_valid_out,
  output logic bus_eoi_out,
  input wire logic bus_accept_in,
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_byte_in,
  output logic rx_accept_out,
  output logic read_done_out,
  output logic dma_en_out,
  output logic [1:0] dma_channel_out,
  output logic irq_out
);
  logic [15:0] board_term, prev_value, active_term;
  logic [15:0] unit_term [UNITS];
  logic board_eot, method, use_unit, dph_write, wr_strobe, active_eot, read_hit, write_end;
  logic unit_eot [UNITS];
  logic [1:0] unit_sel, cur_unit;
  logic [7:0] error_code, dph_addr, match_byte;
  logic [IRQ_BITS-1:0] irq_status, irq_mask, events;
  xfer_state_t state;
  term_cfg_if cfg_bus();

  // Per-unit setting applies only when the transfer names a unit
  assign active_term = use_unit ? unit_term[cur_unit] : board_term;
  assign active_eot = use_unit ? unit_eot[cur_unit] : board_eot;
  assign cfg_bus.term_char = active_term[TERM_CHAR_LSB +: 8];
  assign cfg_bus.read_end_en = active_term[READ_END_BIT];
  assign cfg_bus.write_eoi_en = active_term[WRITE_EOI_BIT];
  assign cfg_bus.full_cmp = active_term[FULL_CMP_BIT];
  assign cfg_bus.eot_en = active_eot;
  assign match_byte = (state == XFER_WRITE) ? tx_byte_in : rx_byte_in;

  term_match u_match
  (
    .cfg(cfg_bus),
    .byte_in(match_byte),
    .last_in(tx_last_in),
    .read_hit_out(read_hit),
    .write_end_out(write_end)
  );

  // AHB-Lite address phase capture; zero wait states, always OKAY
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      dph_write <= 1'b0;
      dph_addr <= 8'h00;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end
    else
    begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
      if (hready_in)
      begin
        dph_write <= hsel_in & hwrite_in & (htrans_in == HTRANS_NONSEQ) & (hsize_in == HSIZE_WORD);
        dph_addr <= haddr_in[7:0];
      end
    end
  end

  assign wr_strobe = dph_write;

  // Settings, previous value and capability error
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      board_term <= TERM_RESET;
      board_eot <= 1'b1;
      method <= 1'b0;
      unit_sel <= 2'h0;
      prev_value <= 16'h0000;
      error_code <= 8'h00;
      for (int i = 0; i < UNITS; i++)
      begin
        unit_term[i] <= TERM_RESET;
        unit_eot[i] <= 1'b1;
      end
    end
    else if (wr_strobe)
    begin
      case (dph_addr)
        REG_BOARD_TERM:
        begin
          prev_value <= board_term;
          board_term <= hwdata_in[15:0];
        end
        REG_BOARD_EOT:
        begin
          prev_value <= {15'h0000, board_eot};
          board_eot <= |hwdata_in;
        end
        REG_METHOD:
        begin
          if (!DMA_CAPABLE)
          begin
            error_code <= (|hwdata_in) ? CAP_ERROR_CODE : error_code;
          end
          else
          begin
            prev_value <= {15'h0000, method};
            method <= |hwdata_in;
          end
        end
        REG_UNIT_SEL: unit_sel <= hwdata_in[1:0];
        REG_UNIT_TERM:
        begin
          prev_value <= unit_term[unit_sel];
          unit_term[unit_sel] <= hwdata_in[15:0];
        end
        REG_UNIT_EOT:
        begin
          prev_value <= {15'h0000, unit_eot[unit_sel]};
          unit_eot[unit_sel] <= |hwdata_in;
        end
        REG_ERROR: error_code <= 8'h00;
        REG_REINIT:
        begin
          // Going online or opening restores defaults
          board_term <= TERM_RESET;
          board_eot <= 1'b1;
          method <= 1'b0;
          for (int i = 0; i < UNITS; i++)
          begin
            unit_term[i] <= TERM_RESET;
            unit_eot[i] <= 1'b1;
          end
        end
        default: ;
      endcase
    end
  end

  // DMA select outputs
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      dma_en_out <= 1'b0;
      dma_channel_out <= 2'h0;
    end
    else
    begin
      dma_en_out <= method & DMA_CAPABLE;
      dma_channel_out <= DMA_CHANNEL;
    end
  end

  // Transfer sequencing
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state <= XFER_IDLE;
      use_unit <= 1'b0;
      cur_unit <= 2'h0;
    end
    else
    begin
      case (state)
        XFER_IDLE:
        begin
          if (xfer_start_in)
          begin
            state <= xfer_write_in ? XFER_WRITE : XFER_READ;
            use_unit <= xfer_unit_en_in;
            cur_unit <= xfer_unit_in;
          end
        end
        XFER_READ:
        begin
          if (rx_valid_in && read_hit)
          begin
            state <= XFER_IDLE;
          end
        end
        XFER_WRITE:
        begin
          if (tx_valid_in && tx_accept_out && tx_last_in)
          begin
            state <= XFER_IDLE;
          end
        end
        default: state <= XFER_IDLE;
      endcase
    end
  end

  // Write path: host bytes only, END with the byte it marks
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      bus_data_out <= 8'h00;
      bus_data_valid_out <= 1'b0;
      bus_eoi_out <= 1'b0;
      tx_accept_out <= 1'b0;
    end
    else
    begin
      tx_accept_out <= 1'b0;
      if (bus_data_valid_out && bus_accept_in)
      begin
        bus_data_valid_out <= 1'b0;
        bus_eoi_out <= 1'b0;
      end
      else if (!bus_data_valid_out && state == XFER_WRITE && tx_valid_in && !tx_accept_out)
      begin
        bus_data_out <= tx_byte_in;
        bus_eoi_out <= write_end;
        bus_data_valid_out <= 1'b1;
        tx_accept_out <= 1'b1;
      end
    end
  end

  // Read path
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rx_accept_out <= 1'b0;
      read_done_out <= 1'b0;
    end
    else
    begin
      rx_accept_out <= (state == XFER_READ) & rx_valid_in & ~rx_accept_out;
      read_done_out <= (state == XFER_READ) & rx_valid_in & read_hit;
    end
  end

  assign events[IRQ_READ_END] = (state == XFER_READ) & rx_valid_in & read_hit;
  assign events[IRQ_CAP_ERR] = wr_strobe & (dph_addr == REG_METHOD) & (|hwdata_in) & ~DMA_CAPABLE;
  assign events[IRQ_WRITE_DONE] = bus_data_valid_out & bus_accept_in & bus_eoi_out;

  // Sticky status, write one to clear; a new event wins
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      irq_status <= '0;
      irq_mask <= '0;
      irq_out <= 1'b0;
    end
    else
    begin
      irq_out <= |(irq_status & irq_mask);
      if (wr_strobe && dph_addr == REG_IRQ_MASK)
      begin
        irq_mask <= hwdata_in[IRQ_BITS-1:0];
      end
      if (wr_strobe && dph_addr == REG_IRQ_STATUS)
      begin
        irq_status <= (irq_status & ~hwdata_in[IRQ_BITS-1:0]) | events;
      end
      else
      begin
        irq_status <= irq_status | events;
      end
    end
  end

  // Read data, registered in the data phase
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      hrdata_out <= 32'h0000_0000;
    end
    else if (hready_in && hsel_in && !hwrite_in && htrans_in == HTRANS_NONSEQ)
    begin
      case (haddr_in[7:0])
        REG_BOARD_TERM: hrdata_out <= {16'h0000, board_term};
        REG_BOARD_EOT: hrdata_out <= {31'h0, board_eot};
        REG_METHOD: hrdata_out <= {31'h0, method};
        REG_UNIT_SEL: hrdata_out <= {30'h0, unit_sel};
        REG_UNIT_TERM: hrdata_out <= {16'h0000, unit_term[unit_sel]};
        REG_UNIT_EOT: hrdata_out <= {31'h0, unit_eot[unit_sel]};
        REG_PREV_VALUE: hrdata_out <= {16'h0000, prev_value};
        REG_ERROR: hrdata_out <= {24'h0, error_code};
        REG_IRQ_STATUS: hrdata_out <= {29'h0, irq_status};
        REG_IRQ_MASK: hrdata_out <= {29'h0, irq_mask};
        REG_STATUS: hrdata_out <= {28'h0, dma_channel_out, state};
        default: hrdata_out <= 32'h0000_0000;
      endcase
    end
  end

  a_eoi_with_byte: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    bus_eoi_out |-> bus_data_valid_out)
    else $error("EOI without a data byte");
  a_byte_from_host: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    $rose(bus_data_valid_out) |-> bus_data_out == $past(tx_byte_in) && $past(tx_valid_in))
    else $error("Byte on bus not from host");
  a_eoi_cause: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    $rose(bus_data_valid_out) |-> bus_eoi_out == $past(write_end))
    else $error("END marking wrong");
  a_read_stop: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    state == XFER_READ && rx_valid_in && read_hit |=> state == XFER_IDLE && read_done_out)
    else $error("Read did not end on terminator");
  a_dma_follow: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    ##1 dma_en_out == $past(method & DMA_CAPABLE))
    else $error("DMA enable not following method");
  a_cap_error: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    events[IRQ_CAP_ERR] |=> error_code == CAP_ERROR_CODE && !method)
    else $error("Capability error not reported");
  a_prev_term: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    wr_strobe && dph_addr == REG_BOARD_TERM |=> prev_value == $past(board_term))
    else $error("Previous setting not returned");
  a_term_hold: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    !(wr_strobe && (dph_addr == REG_BOARD_TERM || dph_addr == REG_REINIT)) |=> $stable(board_term))
    else $error("Setting changed without write");
  a_irq_level: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    ##1 irq_out == $past(|(irq_status & irq_mask)))
    else $error("Interrupt level wrong");
endmodule

// ### core/term_pkg.sv
// Package for the transfer termination controller: register map, field layout, encodings.
// Assumes a 32-bit AHB-Lite slave port and one 50 MHz clock.
package term_pkg;
  localparam logic [7:0] REG_BOARD_TERM = 8'h00;
  localparam logic [7:0] REG_BOARD_EOT = 8'h04;
  localparam logic [7:0] REG_METHOD = 8'h08;
  localparam logic [7:0] REG_UNIT_SEL = 8'h0c;
  localparam logic [7:0] REG_UNIT_TERM = 8'h10;
  localparam logic [7:0] REG_UNIT_EOT = 8'h14;
  localparam logic [7:0] REG_PREV_VALUE = 8'h18;
  localparam logic [7:0] REG_ERROR = 8'h1c;
  localparam logic [7:0] REG_REINIT = 8'h20;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h24;
  localparam logic [7:0] REG_IRQ_MASK = 8'h28;
  localparam logic [7:0] REG_STATUS = 8'h2c;
  localparam int TERM_CHAR_LSB = 0;
  localparam int READ_END_BIT = 10;
  localparam int WRITE_EOI_BIT = 11;
  localparam int FULL_CMP_BIT = 12;
  localparam logic [15:0] TERM_RESET = 16'h000a;
  localparam logic [1:0] DMA_CHANNEL_RESET = 2'h1;
  localparam int IRQ_READ_END = 0;
  localparam int IRQ_CAP_ERR = 1;
  localparam int IRQ_WRITE_DONE = 2;
  localparam int IRQ_BITS = 3;
  localparam logic [7:0] CAP_ERROR_CODE = 8'h0b;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  typedef enum logic [1:0]
  {
    XFER_IDLE = 2'b00,
    XFER_READ = 2'b01,
    XFER_WRITE = 2'b10
  } xfer_state_t;
endpackage

// ### core/term_cfg_if.sv
// Interface carrying the effective termination setting from the register file to the matcher.
// Assumes one clock domain.
`timescale 1ns/1ns
interface term_cfg_if;
  logic [7:0] term_char;
  logic read_end_en;
  logic write_eoi_en;
  logic full_cmp;
  logic eot_en;
  modport src
  (
    output term_char, read_end_en, write_eoi_en, full_cmp, eot_en
  );
  modport dst
  (
    input term_char, read_end_en, write_eoi_en, full_cmp, eot_en
  );
endinterface

// ### core/term_match.sv
// Byte matcher: decides read end and write END marking from the active setting.
// Assumes cfg is stable during a byte.
`timescale 1ns/1ns
module term_match
  import term_pkg::*;
(
  term_cfg_if.dst cfg,
  input wire logic [7:0] byte_in,
  input wire logic last_in,
  output logic read_hit_out,
  output logic write_end_out
);
  function automatic logic char_eq(input logic [7:0] a, input logic [7:0] b, input logic full);
    char_eq = full ? (a == b) : (a[6:0] == b[6:0]);
  endfunction
  logic eq;
  assign eq = char_eq(byte_in, cfg.term_char, cfg.full_cmp);
  assign read_hit_out = cfg.read_end_en & eq;
  // Either cause marks the byte
  assign write_end_out = (cfg.write_eoi_en & eq) | (cfg.eot_en & last_in);
endmodule

// ### verification/gpib_partner.sv
// Far-side model: a listener that takes bus bytes and a talker that offers read bytes.
// Assumes the controller holds each bus byte until it sees the accept.
`timescale 1ns/1ns
module gpib_partner
(
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic [3:0] stall_in,
  input wire logic [7:0] bus_data_in,
  input wire logic bus_data_valid_in,
  input wire logic bus_eoi_in,
  output logic bus_accept_out,
  output logic rx_valid_out,
  output logic [7:0] rx_byte_out,
  input wire logic rx_accept_in
);
  logic [3:0] wait_cnt;
  logic [8:0] seen [$];
  initial
  begin
    rx_valid_out = 1'b0;
    rx_byte_out = 8'h00;
  end
  // Listener waits stall_in cycles, then logs byte and END at the handshake edge
  always @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      bus_accept_out <= 1'b0;
      wait_cnt <= 4'h0;
    end
    else if (bus_accept_out)
    begin
      bus_accept_out <= 1'b0;
      wait_cnt <= 4'h0;
      if (bus_data_valid_in)
        seen.push_back({bus_eoi_in, bus_data_in});
    end
    else if (bus_data_valid_in)
    begin
      if (wait_cnt == stall_in)
        bus_accept_out <= 1'b1;
      else
        wait_cnt <= wait_cnt + 4'h1;
    end
  end
  // Talker holds a byte until accepted, then shows its inverse
  task automatic talk(input logic [7:0] b);
    int n;
    @(posedge clk_sys_in);
    rx_valid_out <= 1'b1;
    rx_byte_out <= b;
    n = 0;
    do
    begin
      @(posedge clk_sys_in);
      n++;
    end
    while (rx_accept_in !== 1'b1 && n < 50);
    rx_valid_out <= 1'b0;
    rx_byte_out <= ~b;
  endtask
endmodule

// ### verification/gpib_transfer_termination_control_tb.sv
// Self-checking bench for the termination controller with a far-side byte partner.
// Assumes zero-wait register bus answers and one 50 MHz clock.
`timescale 1ns/1ns
module gpib_transfer_termination_control_tb
  import term_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = HSIZE_WORD;
  logic [31:0] hwdata = 32'h0;
  logic xfer_start = 1'b0;
  logic xfer_write = 1'b0;
  logic unit_en = 1'b0;
  logic [1:0] unit = 2'h1;
  logic tx_valid = 1'b0;
  logic [7:0] tx_byte = 8'h00;
  logic tx_last = 1'b0;
  logic [3:0] stall = 4'h0;
  logic [31:0] hrdata, rdata;
  logic [7:0] bus_data, rx_byte;
  logic [1:0] dma_ch;
  logic hready, hresp, tx_accept, bus_valid, bus_eoi, bus_accept;
  logic rx_valid, rx_accept, read_done, dma_en, irq;
  logic [31:0] hrdata_lim, rdata_lim;
  logic dma_en_lim;
  logic [7:0] wbytes [4] = '{8'h31, 8'h0a, 8'h8a, 8'h33};
  int fails = 0;
  int n_compared = 0;
  initial
  begin
    forever #10 clk_sys = ~clk_sys;
  end
  term_ctrl term_ctrl_inst
  (
    .clk_sys_in(clk_sys), .rst_b_in(rst_b), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .xfer_start_in(xfer_start), .xfer_write_in(xfer_write), .xfer_unit_en_in(unit_en),
    .xfer_unit_in(unit), .tx_valid_in(tx_valid), .tx_byte_in(tx_byte),
    .tx_last_in(tx_last), .tx_accept_out(tx_accept), .bus_data_out(bus_data),
    .bus_data_valid_out(bus_valid), .bus_eoi_out(bus_eoi), .bus_accept_in(bus_accept),
    .rx_valid_in(rx_valid), .rx_byte_in(rx_byte), .rx_accept_out(rx_accept),
    .read_done_out(read_done), .dma_en_out(dma_en), .dma_channel_out(dma_ch),
    .irq_out(irq)
  );
  gpib_partner gpib_partner_inst
  (
    .clk_sys_in(clk_sys), .rst_b_in(rst_b), .stall_in(stall), .bus_data_in(bus_data),
    .bus_data_valid_in(bus_valid), .bus_eoi_in(bus_eoi), .bus_accept_out(bus_accept),
    .rx_valid_out(rx_valid), .rx_byte_out(rx_byte), .rx_accept_in(rx_accept)
  );
  // Second controller built without DMA, shares the bus, shows the capability error path
  term_ctrl #(.DMA_CAPABLE(1'b0)) term_ctrl_nodma_inst
  (
    .clk_sys_in(clk_sys), .rst_b_in(rst_b), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata_lim), .hreadyout_out(), .hresp_out(),
    .xfer_start_in(xfer_start), .xfer_write_in(xfer_write), .xfer_unit_en_in(unit_en),
    .xfer_unit_in(unit), .tx_valid_in(tx_valid), .tx_byte_in(tx_byte),
    .tx_last_in(tx_last), .tx_accept_out(), .bus_data_out(), .bus_data_valid_out(),
    .bus_eoi_out(), .bus_accept_in(bus_accept), .rx_valid_in(rx_valid),
    .rx_byte_in(rx_byte), .rx_accept_out(), .read_done_out(), .dma_en_out(dma_en_lim),
    .dma_channel_out(), .irq_out()
  );
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %0t word got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_flag(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %0t flag got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (hready !== 1'b1 && n < 50);
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rdata = hrdata;
    rdata_lim = hrdata_lim;
    check_flag(hresp, 1'b0);
  endtask
  task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    check_word(rdata, exp);
  endtask
  task automatic start(input logic w, input logic ue);
    xfer_start <= 1'b1;
    xfer_write <= w;
    unit_en <= ue;
    @(posedge clk_sys);
    xfer_start <= 1'b0;
  endtask
  task automatic send(input logic [7:0] b, input logic last);
    int n;
    tx_valid <= 1'b1;
    tx_byte <= b;
    tx_last <= last;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (tx_accept !== 1'b1 && n < 50);
    tx_valid <= 1'b0;
    tx_last <= 1'b0;
    tx_byte <= ~b;
    @(posedge clk_sys);
  endtask
  task automatic watch_done(input logic exp);
    logic hit;
    logic acc;
    hit = 1'b0;
    acc = 1'b0;
    repeat (6)
    begin
      @(posedge clk_sys);
      hit = hit | read_done;
      acc = acc | rx_accept;
    end
    check_flag(hit, exp);
    check_flag(acc, 1'b1);
  endtask
  task automatic read_run(input logic [15:0] term, input logic [7:0] miss, input logic [7:0] hit);
    ahb(1'b1, REG_BOARD_TERM, {16'h0, term});
    start(1'b0, 1'b0);
    // The done pulse stands one cycle, so it is watched while the byte is offered
    fork
      gpib_partner_inst.talk(miss);
      watch_done(1'b0);
    join
    fork
      gpib_partner_inst.talk(hit);
      watch_done(1'b1);
    join
    $display("read test %h done", term);
  endtask
  task automatic burst(input logic ue, input logic [3:0] exp);
    int n;
    stall <= stall + 4'h3;
    start(1'b1, ue);
    for (int i = 0; i < 4; i++)
      send(wbytes[i], i == 3);
    n = 0;
    while (gpib_partner_inst.seen.size() < 4 && n < 100)
    begin
      @(posedge clk_sys);
      n++;
    end
    check_word(32'(gpib_partner_inst.seen.size()), 32'h4);
    for (int i = 0; i < 4; i++)
      check_word({23'h0, gpib_partner_inst.seen[i]}, {23'h0, exp[i], wbytes[i]});
    gpib_partner_inst.seen.delete();
    $display("write test %h done", exp);
  endtask
  task automatic write_run(input logic [15:0] term, input logic eot, input logic [3:0] exp);
    ahb(1'b1, REG_BOARD_TERM, {16'h0, term});
    ahb(1'b1, REG_BOARD_EOT, {31'h0, eot});
    burst(1'b0, exp);
  endtask
  task automatic irq_test();
    check_flag(irq, 1'b0);
    ahb(1'b1, REG_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk_sys);
    check_flag(irq, 1'b1);
    ahb(1'b1, REG_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge clk_sys);
    check_flag(irq, 1'b0);
    rd_check(REG_IRQ_STATUS, 32'h0);
    ahb(1'b1, REG_IRQ_MASK, 32'h0);
    $display("interrupt test done");
  endtask
  task automatic dma_test();
    ahb(1'b1, REG_METHOD, 32'h1);
    repeat (2) @(posedge clk_sys);
    check_flag(dma_en, 1'b1);
    check_flag(dma_en_lim, 1'b0);
    check_word({30'h0, dma_ch}, {30'h0, DMA_CHANNEL_RESET});
    rd_check(REG_PREV_VALUE, 32'h0);
    // Board setting written by the first read test stays as previous value in the DMA-less unit
    check_word(rdata_lim, 32'h040a);
    rd_check(REG_ERROR, 32'h0);
    check_word(rdata_lim, {24'h0, CAP_ERROR_CODE});
    ahb(1'b1, REG_METHOD, 32'h0);
    repeat (2) @(posedge clk_sys);
    check_flag(dma_en, 1'b0);
    rd_check(REG_PREV_VALUE, 32'h1);
    check_word(rdata_lim, 32'h040a);
    rd_check(REG_METHOD, 32'h0);
    check_word(rdata_lim, 32'h0);
    $display("method test done");
  endtask
  task automatic defaults_test();
    rd_check(REG_BOARD_TERM, {16'h0, TERM_RESET});
    rd_check(REG_BOARD_EOT, 32'h1);
    rd_check(REG_METHOD, 32'h0);
    rd_check(8'h3c, 32'h0);
    $display("defaults test done");
  endtask
  task automatic unit_test();
    ahb(1'b1, REG_BOARD_TERM, 32'h0);
    ahb(1'b1, REG_BOARD_EOT, 32'h0);
    ahb(1'b1, REG_UNIT_SEL, 32'h1);
    ahb(1'b1, REG_UNIT_TERM, 32'h0833);
    rd_check(REG_PREV_VALUE, {16'h0, TERM_RESET});
    ahb(1'b1, REG_UNIT_EOT, 32'h0);
    rd_check(REG_PREV_VALUE, 32'h1);
    burst(1'b1, 4'h8);
    burst(1'b0, 4'h0);
    $display("unit test done");
  endtask
  task automatic reinit_test();
    ahb(1'b1, REG_REINIT, 32'h1);
    rd_check(REG_BOARD_TERM, {16'h0, TERM_RESET});
    rd_check(REG_BOARD_EOT, 32'h1);
    rd_check(REG_UNIT_TERM, {16'h0, TERM_RESET});
    $display("reinit test done");
  endtask
  task automatic end_of_test();
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    defaults_test();
    read_run(16'h040a, 8'h41, 8'h8a);
    irq_test();
    read_run(16'h1482, 8'h02, 8'h82);
    dma_test();
    write_run(16'h080a, 1'b0, 4'h6);
    write_run(16'h180a, 1'b0, 4'h2);
    write_run(16'h000a, 1'b1, 4'h8);
    write_run(16'h080a, 1'b1, 4'he);
    unit_test();
    reinit_test();
    end_of_test();
  end
  initial
  begin
    #400000;
    fails++;
    $display("ERROR %0t watchdog expired", $time);
    end_of_test();
  end
endmodule
